/* design/cmsc_pkg.sv */
// Constants, types and status codes for the command and sleep controller.
// Assumes a 100 MHz system clock; all timing derives from that rate.
package cmsc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_10MS = 10;     // 1 ms ticks per 10 ms step
  localparam int STEPS_PER_100MS = 10;    // 10 ms steps per 100 ms
  localparam logic [15:0] POLL_DEFAULT = 16'h000A; // 100 ms in 10 ms
  localparam int ESC_COUNT = 3;           // Escape characters in a row
  localparam logic [7:0] API_APPLY_TYPE = 8'h08;

  // ---------------------------------------------------------------
  // Register indices and operations
  // ---------------------------------------------------------------
  localparam int NREG = 11;
  typedef enum logic [3:0] {
    R_ASSOC = 4'h0, R_CT = 4'h1, R_GT = 4'h2, R_CC = 4'h3,
    R_SM = 4'h4, R_SN = 4'h5, R_SP = 4'h6, R_ST = 4'h7,
    R_SO = 4'h8, R_WH = 4'h9, R_PO = 4'hA
  } cmsc_reg_e;
  typedef enum logic [1:0] {
    OP_READ = 2'h0, OP_WRITE = 2'h1, OP_APPLY = 2'h2, OP_LEAVE = 2'h3
  } cmsc_op_e;

  // Reset values and legal ranges, index 10 down to 0
  localparam logic [NREG-1:0][15:0] RST_VAL = {
    16'h0000, 16'h0000, 16'h0000, 16'h1388, 16'h0020, 16'h0001,
    16'h0000, 16'h002B, 16'h03E8, 16'h0064, 16'h00FF};
  localparam logic [NREG-1:0][15:0] MIN_VAL = {
    16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0020, 16'h0001,
    16'h0000, 16'h0000, 16'h0001, 16'h0002, 16'h0000};
  localparam logic [NREG-1:0][15:0] MAX_VAL = {
    16'h03E8, 16'hFFFF, 16'h00FF, 16'hFFFF, 16'h0AF0, 16'hFFFF,
    16'h0005, 16'h00FF, 16'h0CE4, 16'h1770, 16'h00FF};
  localparam logic [15:0] SO_USED = 16'h0006;
  localparam int SO_FORCE_WAKE = 1;       // Bit value 0x02
  localparam int SO_FULL_SLEEP = 2;       // Bit value 0x04

  // Sleep modes
  localparam logic [15:0] SM_PIN = 16'h0002;
  localparam logic [15:0] SM_CYCLIC = 16'h0004;
  localparam logic [15:0] SM_CYC_PIN = 16'h0005;

  // ---------------------------------------------------------------
  // Association status codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    J_OK = 4'h0, J_NO_PANS = 4'h1, J_NO_VALID = 4'h2, J_CLOSED = 4'h3,
    J_NO_BEACON = 4'h4, J_BAD_STATE = 4'h5, J_JOIN_FAIL = 4'h6,
    J_COORD_FAIL = 4'h7, J_COORD_CHECK = 4'h8, J_LEAVE_FAIL = 4'h9,
    J_NO_RESP = 4'hA, J_NO_KEY = 4'hB, J_BAD_LINK_KEY = 4'hC
  } cmsc_join_e;
  localparam logic [7:0] AS_UNKNOWN = 8'hFF;

  function automatic logic [7:0] assoc_code(cmsc_join_e j);
    case (j)
      J_OK: assoc_code = 8'h00;
      J_NO_PANS: assoc_code = 8'h21;
      J_NO_VALID: assoc_code = 8'h22;
      J_CLOSED: assoc_code = 8'h23;
      J_NO_BEACON: assoc_code = 8'h24;
      J_BAD_STATE: assoc_code = 8'h25;
      J_JOIN_FAIL: assoc_code = 8'h27;
      J_COORD_FAIL: assoc_code = 8'h2A;
      J_COORD_CHECK: assoc_code = 8'h2B;
      J_LEAVE_FAIL: assoc_code = 8'h2C;
      J_NO_RESP: assoc_code = 8'hAB;
      J_NO_KEY: assoc_code = 8'hAD;
      J_BAD_LINK_KEY: assoc_code = 8'hAF;
      default: assoc_code = AS_UNKNOWN;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cmsc_char_s;
  typedef struct packed {
    logic valid;
    cmsc_op_e op;
    cmsc_reg_e idx;
    logic [15:0] data;
  } cmsc_cmd_s;
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } cmsc_rsp_s;

endpackage

/* design/cmsc_top.sv */
// Serial command-state, parameter and sleep timing controller.
// Assumes a UART receiver and a command parser on clk_sys, and a
// network stack that reports join outcomes and radio activity.
//
// Overview of operation
// - Status reads 0x00 joined, 0xFF undetermined
// - Scan failures report 0x21 to 0x24
// - Join failures report 0x27, 0xAB, 0xAD, 0xAF
// - Report 0x2A, 0x2B, 0x2C and 0x25
// - Command state times out, 100 ms units
// - Leave command exits command state at once
// - Escape needs guard silence before and after
// - Escape character programmable, resets to 0x2B
// - Sleep mode codes; nonzero means end device
// - Nonzero mode needs coordinator off; rejoin on zero/nonzero role change
// - Sleep line asserted once per period count
// - Sleep duration 0x20 to 0xAF0, 10 ms
// - Parent holds messages for its sleep duration
// - Wake timer restarts on data, expiry sleeps
// - Option 0x02 full wake, 0x04 full sleep
// - Host wake delay, cut short by serial input
// - Poll rate zero is 100 ms, else 10 ms
// - Writes pend until apply, leave or API frame type 0x08
// - Action commands act at once
`timescale 1ns/1ps

module cmsc_top #(
  parameter int MS_CYC = cmsc_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire cmsc_pkg::cmsc_char_s rx_char,
  output cmsc_pkg::cmsc_char_s pass_char,
  input wire cmsc_pkg::cmsc_cmd_s cmd,
  output cmsc_pkg::cmsc_rsp_s rsp,
  input wire logic api_valid,
  input wire logic [7:0] api_type,
  input wire logic join_done,
  input wire cmsc_pkg::cmsc_join_e join_outcome,
  input wire logic coord_enable,
  input wire logic rf_rx,
  input wire logic rf_pending,
  input wire logic sleep_pin,
  output logic cmd_mode,
  output logic on_sleep,
  output logic sleep_now,
  output logic host_tx_ok,
  output logic poll_tick,
  output logic rejoin_req,
  output logic [15:0] parent_hold
);

  // -------------------------------------------------------------
  // Parameter check
  // -------------------------------------------------------------
  if (MS_CYC < 1) begin : g_bad_ms
    $error("MS_CYC must be at least one cycle");
  end

  // -------------------------------------------------------------
  // Time base: 1 ms, 10 ms and 100 ms ticks
  // -------------------------------------------------------------
  logic [31:0] ms_cnt_r;
  logic [3:0] t10_cnt_r;
  logic [3:0] t100_cnt_r;
  logic tick1_r;
  logic tick10_r;
  logic tick100_r;

  // Free-running divider chain
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ms_cnt_r <= 32'h0;
      t10_cnt_r <= 4'h0;
      t100_cnt_r <= 4'h0;
      tick1_r <= 1'b0;
      tick10_r <= 1'b0;
      tick100_r <= 1'b0;
    end else begin
      tick1_r <= 1'b0;
      tick10_r <= 1'b0;
      tick100_r <= 1'b0;
      if (ms_cnt_r >= 32'(MS_CYC - 1)) begin
        ms_cnt_r <= 32'h0;
        tick1_r <= 1'b1;
      end else begin
        ms_cnt_r <= ms_cnt_r + 32'h1;
      end
      if (tick1_r) begin
        if (t10_cnt_r == 4'(cmsc_pkg::TICKS_PER_10MS - 1)) begin
          t10_cnt_r <= 4'h0;
          tick10_r <= 1'b1;
        end else begin
          t10_cnt_r <= t10_cnt_r + 4'h1;
        end
      end
      if (tick10_r) begin
        if (t100_cnt_r == 4'(cmsc_pkg::STEPS_PER_100MS - 1)) begin
          t100_cnt_r <= 4'h0;
          tick100_r <= 1'b1;
        end else begin
          t100_cnt_r <= t100_cnt_r + 4'h1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // Parameter store: pending and active copies
  // -------------------------------------------------------------
  logic [cmsc_pkg::NREG-1:0][15:0] pend_w;
  logic [cmsc_pkg::NREG-1:0][15:0] act_w;
  logic wr_ok;
  logic wr_en;
  logic commit;
  logic is_act;

  // Range and coordinator checks on a write
  always_comb begin
    wr_ok = (cmd.data >= cmsc_pkg::MIN_VAL[cmd.idx]) &&
            (cmd.data <= cmsc_pkg::MAX_VAL[cmd.idx]) &&
            (cmd.idx != cmsc_pkg::R_ASSOC) &&
            (cmd.idx <= cmsc_pkg::R_PO);
    if (cmd.idx == cmsc_pkg::R_SM) begin
      if (cmd.data == 16'h0003) begin
        wr_ok = 1'b0;
      end
      if (cmd.data != 16'h0000 && coord_enable) begin
        wr_ok = 1'b0;
      end
    end
    if (cmd.idx == cmsc_pkg::R_SO &&
        (cmd.data & ~cmsc_pkg::SO_USED) != 16'h0) begin
      wr_ok = 1'b0;
    end
  end

  assign wr_en = cmd.valid && cmd.op == cmsc_pkg::OP_WRITE && wr_ok;
  assign is_act = cmd.valid && (cmd.op == cmsc_pkg::OP_APPLY ||
                                cmd.op == cmsc_pkg::OP_LEAVE);
  assign commit = is_act ||
                  (api_valid && api_type == cmsc_pkg::API_APPLY_TYPE);

  assign pend_w[0] = cmsc_pkg::RST_VAL[0];
  assign act_w[0] = cmsc_pkg::RST_VAL[0];

  // One pending and one active word per parameter
  for (genvar i = 1; i < cmsc_pkg::NREG; i++) begin : g_reg
    logic [15:0] pend_r;
    logic [15:0] act_r;
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        pend_r <= cmsc_pkg::RST_VAL[i];
        act_r <= cmsc_pkg::RST_VAL[i];
      end else begin
        if (wr_en && cmd.idx == 4'(i)) begin
          pend_r <= cmd.data;
        end
        if (commit) begin
          act_r <= pend_r;
        end
      end
    end
    assign pend_w[i] = pend_r;
    assign act_w[i] = act_r;
  end

  // -------------------------------------------------------------
  // Association status
  // -------------------------------------------------------------
  logic [7:0] assoc_r;

  // Undetermined until the stack reports an outcome
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      assoc_r <= cmsc_pkg::AS_UNKNOWN;
    end else if (join_done) begin
      assoc_r <= cmsc_pkg::assoc_code(join_outcome);
    end
  end

  // Read answer and write refusal, one cycle after the request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= cmd.valid;
      rsp.err <= cmd.valid && ((cmd.op == cmsc_pkg::OP_WRITE && !wr_ok)
                 || cmd.idx > cmsc_pkg::R_PO);
      rsp.data <= (cmd.idx == cmsc_pkg::R_ASSOC) ? {8'h00, assoc_r}
                  : (cmd.idx > cmsc_pkg::R_PO) ? 16'h0000
                  : pend_w[cmd.idx];
    end
  end

  // Role change on commit forces a rejoin
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rejoin_req <= 1'b0;
    end else begin
      rejoin_req <= commit &&
        ((pend_w[cmsc_pkg::R_SM] != 16'h0) !=
         (act_w[cmsc_pkg::R_SM] != 16'h0));
    end
  end

  // -------------------------------------------------------------
  // Escape sequence and command state
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    E_WAIT = 3'h0, E_ARMED = 3'h1, E_SEQ = 3'h2,
    E_POST = 3'h3, E_CMD = 3'h4
  } cmsc_esc_e;
  cmsc_esc_e esc_r;
  logic [15:0] quiet_ms_r;
  logic [1:0] esc_n_r;
  logic [15:0] ct_cnt_r;
  logic gt_met;
  logic leave;

  assign gt_met = quiet_ms_r >= act_w[cmsc_pkg::R_GT];
  assign leave = cmd.valid && cmd.op == cmsc_pkg::OP_LEAVE;

  // Silence since the last received character
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      quiet_ms_r <= 16'h0;
    end else if (rx_char.valid) begin
      quiet_ms_r <= 16'h0;
    end else if (tick1_r && quiet_ms_r != 16'hFFFF) begin
      quiet_ms_r <= quiet_ms_r + 16'h1;
    end
  end

  // Guarded escape detector and command state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      esc_r <= E_WAIT;
      esc_n_r <= 2'h0;
    end else begin
      case (esc_r)
        E_WAIT: begin
          esc_n_r <= 2'h0;
          if (!rx_char.valid && gt_met) begin
            esc_r <= E_ARMED;
          end
        end
        E_ARMED, E_SEQ: begin
          if (rx_char.valid) begin
            if (rx_char.data == act_w[cmsc_pkg::R_CC][7:0]) begin
              esc_n_r <= esc_n_r + 2'h1;
              esc_r <= (esc_n_r == 2'(cmsc_pkg::ESC_COUNT - 1)) ?
                       E_POST : E_SEQ;
            end else begin
              esc_r <= E_WAIT;
            end
          end
        end
        E_POST: begin
          if (rx_char.valid || leave) begin
            esc_r <= E_WAIT;
          end else if (gt_met) begin
            esc_r <= E_CMD;
          end
        end
        E_CMD: begin
          esc_n_r <= 2'h0;
          if (leave) begin
            esc_r <= E_WAIT;
          end else if (ct_cnt_r >= act_w[cmsc_pkg::R_CT]) begin
            esc_r <= E_WAIT;
          end
        end
        default: esc_r <= E_WAIT;
      endcase
    end
  end

  // Refused command: bad write or unknown index
  function automatic logic rsp_bad(cmsc_pkg::cmsc_cmd_s c);
    rsp_bad = (c.op == cmsc_pkg::OP_WRITE && !wr_ok) ||
              c.idx > cmsc_pkg::R_PO;
  endfunction

  // Command timeout counter, cleared by each accepted command
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ct_cnt_r <= 16'h0;
    end else if (esc_r != E_CMD || (cmd.valid && !rsp_bad(cmd))) begin
      ct_cnt_r <= 16'h0;
    end else if (tick100_r && ct_cnt_r != 16'hFFFF) begin
      ct_cnt_r <= ct_cnt_r + 16'h1;
    end
  end

  // Data path and mode flag
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pass_char <= '0;
      cmd_mode <= 1'b0;
    end else begin
      pass_char.valid <= rx_char.valid && esc_r != E_CMD;
      pass_char.data <= rx_char.data;
      cmd_mode <= esc_r == E_CMD;
    end
  end

  // -------------------------------------------------------------
  // Sleep pin synchroniser
  // -------------------------------------------------------------
  logic [2:0] pin_sync_r;
  logic pin_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_sync_r <= 3'h0;
      pin_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], sleep_pin};
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_r <= pin_sync_r[2];
      end
    end
  end

  // -------------------------------------------------------------
  // Sleep sequencer
  // -------------------------------------------------------------
  typedef enum logic [0:0] {S_AWAKE = 1'b0, S_SLEEP = 1'b1} cmsc_slp_e;
  cmsc_slp_e slp_r;
  logic [15:0] wake_ms_r;
  logic [15:0] sp_cnt_r;
  logic [15:0] per_cnt_r;
  logic [15:0] wh_cnt_r;
  logic [15:0] sm;
  logic [15:0] so;
  logic cyc_mode;
  logic pin_mode;
  logic data_in;
  logic per_end;
  logic wake_ok;

  assign sm = act_w[cmsc_pkg::R_SM];
  assign so = act_w[cmsc_pkg::R_SO];
  assign cyc_mode = sm == cmsc_pkg::SM_CYCLIC ||
                    sm == cmsc_pkg::SM_CYC_PIN;
  assign pin_mode = sm == cmsc_pkg::SM_PIN ||
                    sm == cmsc_pkg::SM_CYC_PIN;
  assign data_in = rx_char.valid || rf_rx;
  assign per_end = tick10_r && sp_cnt_r + 16'h1 >= act_w[cmsc_pkg::R_SP];
  // Wake after the full count, or early for pending data
  assign wake_ok = per_cnt_r + 16'h1 >= act_w[cmsc_pkg::R_SN] ||
                   (rf_pending && !so[cmsc_pkg::SO_FULL_SLEEP]);

  // Awake and sleep phases
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      slp_r <= S_AWAKE;
      wake_ms_r <= 16'h0;
      sp_cnt_r <= 16'h0;
      per_cnt_r <= 16'h0;
    end else begin
      case (slp_r)
        S_AWAKE: begin
          sp_cnt_r <= 16'h0;
          per_cnt_r <= 16'h0;
          if (data_in && !so[cmsc_pkg::SO_FORCE_WAKE]) begin
            wake_ms_r <= 16'h0;
          end else if (tick1_r && wake_ms_r != 16'hFFFF) begin
            wake_ms_r <= wake_ms_r + 16'h1;
          end
          if (pin_mode && pin_r) begin
            slp_r <= S_SLEEP;
          end else if (cyc_mode && esc_r != E_CMD &&
                       wake_ms_r >= act_w[cmsc_pkg::R_ST]) begin
            slp_r <= S_SLEEP;
          end
        end
        S_SLEEP: begin
          wake_ms_r <= 16'h0;
          if (per_end) begin
            sp_cnt_r <= 16'h0;
          end else if (tick10_r) begin
            sp_cnt_r <= sp_cnt_r + 16'h1;
          end
          if (!cyc_mode && !pin_mode) begin
            slp_r <= S_AWAKE;
          end else if (pin_mode && !pin_r) begin
            slp_r <= S_AWAKE;
          end else if (cyc_mode && per_end) begin
            if (wake_ok) begin
              per_cnt_r <= 16'h0;
              slp_r <= S_AWAKE;
            end else begin
              per_cnt_r <= per_cnt_r + 16'h1;
            end
          end
        end
        default: slp_r <= S_AWAKE;
      endcase
    end
  end

  // Host wake delay after each wake-up
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wh_cnt_r <= 16'h0;
      host_tx_ok <= 1'b1;
    end else if (slp_r == S_SLEEP) begin
      wh_cnt_r <= act_w[cmsc_pkg::R_WH];
      host_tx_ok <= 1'b0;
    end else if (rx_char.valid || wh_cnt_r == 16'h0) begin
      wh_cnt_r <= 16'h0;
      host_tx_ok <= 1'b1;
    end else if (tick1_r) begin
      wh_cnt_r <= wh_cnt_r - 16'h1;
    end
  end

  // Status lines and parent buffer time
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      on_sleep <= 1'b1;
      sleep_now <= 1'b0;
      parent_hold <= cmsc_pkg::RST_VAL[cmsc_pkg::R_SP];
    end else begin
      on_sleep <= slp_r == S_AWAKE;
      sleep_now <= slp_r == S_SLEEP;
      parent_hold <= act_w[cmsc_pkg::R_SP];
    end
  end

  // -------------------------------------------------------------
  // End-device poll timer
  // -------------------------------------------------------------
  logic [15:0] poll_cnt_r;
  logic [15:0] poll_lim;

  assign poll_lim = (act_w[cmsc_pkg::R_PO] == 16'h0) ?
                    cmsc_pkg::POLL_DEFAULT : act_w[cmsc_pkg::R_PO];

  // One pulse per poll interval while an end device is awake
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      poll_cnt_r <= 16'h0;
      poll_tick <= 1'b0;
    end else begin
      poll_tick <= 1'b0;
      if (sm == 16'h0 || slp_r == S_SLEEP) begin
        poll_cnt_r <= 16'h0;
      end else if (tick10_r) begin
        if (poll_cnt_r + 16'h1 >= poll_lim) begin
          poll_cnt_r <= 16'h0;
          poll_tick <= 1'b1;
        end else begin
          poll_cnt_r <= poll_cnt_r + 16'h1;
        end
      end
    end
  end

endmodule // cmsc_top

/* verif/cmsc_host.sv */
// Host processor model on the serial side of the controller.
// Assumes clk_sys; gaps are counted in clk_sys cycles.
`timescale 1ns/1ps

module cmsc_host (
  input wire logic clk_sys,
  output cmsc_pkg::cmsc_char_s rx_char
);
  initial rx_char = '0;

  // Silence, then one character for one cycle
  task automatic send(input logic [7:0] c, input int gap);
    repeat (gap) @(posedge clk_sys);
    #1 rx_char = {1'b1, c};
    @(posedge clk_sys);
    #1 rx_char = {1'b0, ~c}; // Idle data inverted
  endtask

  // Three escape characters framed by silence
  task automatic escape(input logic [7:0] esc, input int guard);
    for (int i = 0; i < 3; i++) send(esc, (i == 0) ? guard : 2);
    repeat (guard) @(posedge clk_sys) #1;
  endtask
endmodule // cmsc_host

/* verif/cmsc_top_chk.sv */
// Assertion checker for the command and sleep controller.
// Bound into cmsc_top; sees only its ports.
`timescale 1ns/1ps

module cmsc_top_chk #(
  parameter int MS_CYC = cmsc_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire cmsc_pkg::cmsc_char_s rx_char,
  input wire cmsc_pkg::cmsc_char_s pass_char,
  input wire cmsc_pkg::cmsc_cmd_s cmd,
  input wire cmsc_pkg::cmsc_rsp_s rsp,
  input wire logic api_valid,
  input wire logic [7:0] api_type,
  input wire logic cmd_mode,
  input wire logic sleep_now,
  input wire logic host_tx_ok,
  input wire logic poll_tick,
  input wire logic rejoin_req
);
  logic commit;
  logic [15:0] quiet_r;
  // Any apply action at the inputs
  assign commit = (cmd.valid && (cmd.op == cmsc_pkg::OP_APPLY ||
    cmd.op == cmsc_pkg::OP_LEAVE)) ||
    (api_valid && api_type == cmsc_pkg::API_APPLY_TYPE);
  // Cycles since the last received character
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) quiet_r <= 16'h0000;
    else if (rx_char.valid) quiet_r <= 16'h0000;
    else if (quiet_r != 16'hFFFF) quiet_r <= quiet_r + 16'h0001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence leave_s;
    cmd.valid && cmd.op == cmsc_pkg::OP_LEAVE;
  endsequence
  sequence echo_s;
    rx_char.valid ##1 !cmd_mode;
  endsequence

  rsp_after_cmd_a: assert property (cmd.valid |=> rsp.valid)
    else $error("command got no answer");
  rsp_cause_a: assert property (rsp.valid |-> $past(cmd.valid))
    else $error("answer without command");
  status_ro_a: assert property (cmd.valid && cmd.op == cmsc_pkg::OP_WRITE
    && cmd.idx == cmsc_pkg::R_ASSOC |=> rsp.err)
    else $error("status write not refused");
  pass_echo_a: assert property (echo_s |-> pass_char.valid &&
    pass_char.data == $past(rx_char.data))
    else $error("character not passed");
  pass_block_a: assert property (rx_char.valid ##1 cmd_mode |->
    !pass_char.valid)
    else $error("character passed in command state");
  pass_cause_a: assert property (pass_char.valid |-> $past(rx_char.valid))
    else $error("pass without character");
  leave_exit_a: assert property (leave_s |-> ##2 !cmd_mode)
    else $error("leave did not exit");
  entry_guard_a: assert property ($rose(cmd_mode) |->
    $past(quiet_r) != 16'h0000)
    else $error("entry without silence");
  rejoin_cause_a: assert property (rejoin_req |->
    $past(commit) || $past(commit, 2))
    else $error("rejoin without commit");
  asleep_quiet_a: assert property (sleep_now [*2] |-> !host_tx_ok)
    else $error("host output while asleep");
  poll_awake_a: assert property (poll_tick |-> !sleep_now)
    else $error("poll while asleep");
endmodule // cmsc_top_chk

bind cmsc_top cmsc_top_chk #(.MS_CYC(MS_CYC)) chk (.clk_sys(clk_sys),
  .nrst(nrst), .rx_char(rx_char), .pass_char(pass_char), .cmd(cmd),
  .rsp(rsp), .api_valid(api_valid), .api_type(api_type),
  .cmd_mode(cmd_mode), .sleep_now(sleep_now), .host_tx_ok(host_tx_ok),
  .poll_tick(poll_tick), .rejoin_req(rejoin_req));

/* verif/cmsc_test.sv */
// Testbench for the command and sleep controller.
// Drives the command port and the host model; clk_sys at 100 MHz.
`timescale 1ns/1ps

module cmsc_top_test;
  localparam int MSC = 10;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  cmsc_pkg::cmsc_char_s rx_char, pass_char;
  cmsc_pkg::cmsc_cmd_s cmd = '0;
  cmsc_pkg::cmsc_rsp_s rsp, rr;
  logic api_valid = 1'b0;
  logic [7:0] api_type = 8'h00;
  logic join_done = 1'b0;
  cmsc_pkg::cmsc_join_e join_outcome = cmsc_pkg::J_OK;
  logic coord_enable = 1'b0;
  logic rf_rx = 1'b0;
  logic rf_pending = 1'b0;
  logic sleep_pin = 1'b0;
  logic cmd_mode, on_sleep, sleep_now, host_tx_ok, poll_tick, rejoin_req;
  logic [15:0] parent_hold;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] codes [13] = '{8'h00, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
    8'h27, 8'h2A, 8'h2B, 8'h2C, 8'hAB, 8'hAD, 8'hAF};

  always #5 clk_sys = ~clk_sys;

  cmsc_top #(.MS_CYC(MSC)) dut (.clk_sys(clk_sys), .nrst(nrst),
    .rx_char(rx_char), .pass_char(pass_char), .cmd(cmd), .rsp(rsp),
    .api_valid(api_valid), .api_type(api_type), .join_done(join_done),
    .join_outcome(join_outcome), .coord_enable(coord_enable),
    .rf_rx(rf_rx), .rf_pending(rf_pending), .sleep_pin(sleep_pin),
    .cmd_mode(cmd_mode), .on_sleep(on_sleep), .sleep_now(sleep_now),
    .host_tx_ok(host_tx_ok), .poll_tick(poll_tick),
    .rejoin_req(rejoin_req), .parent_hold(parent_hold));
  cmsc_host host (.clk_sys(clk_sys), .rx_char(rx_char));

  // --------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic access(input cmsc_pkg::cmsc_op_e op,
    input cmsc_pkg::cmsc_reg_e idx, input logic [15:0] d);
    @(posedge clk_sys);
    #1 cmd = {1'b1, op, idx, d};
    @(posedge clk_sys);
    #1 cmd.valid = 1'b0;
    rr = rsp;
  endtask
  task automatic rd(input cmsc_pkg::cmsc_reg_e idx, input logic [15:0] e);
    access(cmsc_pkg::OP_READ, idx, 16'h0000);
    check({rr.err, rr.data}, {1'b0, e});
  endtask
  task automatic wr(input cmsc_pkg::cmsc_reg_e idx, input logic [15:0] d,
    input logic e);
    access(cmsc_pkg::OP_WRITE, idx, d);
    check(17'(rr.err), 17'(e));
  endtask
  task automatic api(input logic [7:0] t);
    @(posedge clk_sys);
    #1 api_valid = 1'b1;
    api_type = t;
    @(posedge clk_sys);
    #1 api_valid = 1'b0;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge clk_sys) #1;
    check(17'(s), 17'(v));
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Tests in sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 nrst = 1'b1;
    for (int i = 0; i < 11; i++)
      rd(cmsc_pkg::cmsc_reg_e'(i), cmsc_pkg::RST_VAL[i]);
    $display("test reset values done");
    for (int i = 12; i >= 0; i--) begin
      @(posedge clk_sys);
      #1 join_outcome = cmsc_pkg::cmsc_join_e'(i);
      join_done = 1'b1;
      @(posedge clk_sys);
      #1 join_done = 1'b0;
      rd(cmsc_pkg::R_ASSOC, {8'h00, codes[i]});
    end
    rd(cmsc_pkg::R_ASSOC, 16'h0000);
    wr(cmsc_pkg::R_ASSOC, 16'h0000, 1'b1);
    $display("test status done");
    wr(cmsc_pkg::R_SM, 16'h0003, 1'b1);
    wr(cmsc_pkg::R_SO, 16'h0001, 1'b1);
    wr(cmsc_pkg::R_SO, 16'h0006, 1'b0);
    wr(cmsc_pkg::R_SP, 16'h0AF1, 1'b1);
    wr(cmsc_pkg::R_SP, 16'h0AF0, 1'b0);
    coord_enable = 1'b1;
    wr(cmsc_pkg::R_SM, 16'h0004, 1'b1);
    coord_enable = 1'b0;
    wr(cmsc_pkg::R_SO, 16'h0000, 1'b0);
    check(17'(parent_hold), 17'h00020);
    access(cmsc_pkg::OP_APPLY, cmsc_pkg::R_ASSOC, 16'h0000);
    @(posedge clk_sys);
    #1 check(17'(parent_hold), 17'h00AF0);
    wr(cmsc_pkg::R_SP, 16'h0040, 1'b0);
    api(8'h09);
    @(posedge clk_sys);
    #1 check(17'(parent_hold), 17'h00AF0);
    api(8'h08);
    @(posedge clk_sys);
    #1 check(17'(parent_hold), 17'h00040);
    $display("test settings done");
    wr(cmsc_pkg::R_GT, 16'h0001, 1'b0);
    wr(cmsc_pkg::R_CT, 16'h0002, 1'b0);
    wr(cmsc_pkg::R_CC, 16'h002A, 1'b0);
    access(cmsc_pkg::OP_APPLY, cmsc_pkg::R_ASSOC, 16'h0000);
    host.escape(8'h2B, 3 * MSC);
    check(17'(cmd_mode), 17'h0);
    host.escape(8'h2A, 3 * MSC);
    wait_for(cmd_mode, 1'b1, 20);
    host.send(8'h41, 2);
    check(17'(pass_char.valid), 17'h0);
    access(cmsc_pkg::OP_LEAVE, cmsc_pkg::R_ASSOC, 16'h0000);
    wait_for(cmd_mode, 1'b0, 2);
    host.send(8'h55, 2);
    check(17'(pass_char), 17'h00155);
    host.escape(8'h2A, 3 * MSC);
    wait_for(cmd_mode, 1'b1, 20);
    repeat (900) @(posedge clk_sys);
    #1 check(17'(cmd_mode), 17'h1);
    wait_for(cmd_mode, 1'b0, 1200);
    $display("test command state done");
    wr(cmsc_pkg::R_ST, 16'h0100, 1'b0);
    wr(cmsc_pkg::R_SM, 16'h0004, 1'b0);
    access(cmsc_pkg::OP_APPLY, cmsc_pkg::R_ASSOC, 16'h0000);
    wait_for(rejoin_req, 1'b1, 3);
    wait_for(sleep_now, 1'b1, 3000);
    check(17'(on_sleep), 17'h0);
    wait_for(sleep_now, 1'b0, 6600);
    wait_for(host_tx_ok, 1'b1, 2);
    wait_for(poll_tick, 1'b1, 1100);
    $display("test sleep done");
    finish_test();
  end

  // Watchdog well past the expected run length
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
endmodule // cmsc_top_test
